// file: inc/upper_err_cfg.svh
// Purpose: constants for the upper chain port error flag block
// Assumes: byte-wide read-only status registers
// Notes:   offsets are register indices as printed
`ifndef UPPER_ERR_CFG_SVH
`define UPPER_ERR_CFG_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define CMD_FLAGS_OFS    12'h784
`define RSP_FLAGS_OFS    12'h785
`define IRQ_STAT_OFS     12'h790
`define IRQ_MASK_OFS     12'h791
`define FLAGS_RESET      8'h00

// ----------------------------------------
// command flag bit positions
// ----------------------------------------
`define CMD_CRC_BIT      0
`define CMD_UNEXP_BIT    1
`define CMD_BYTE_BIT     2
`define CMD_SOF_BIT      3
`define CMD_TXDIS_BIT    4
`define CMD_INIT_BIT     5

// ----------------------------------------
// response flag bit positions
// ----------------------------------------
`define RSP_CRC_BIT      0
`define RSP_UNEXP_BIT    1
`define RSP_BYTE_BIT     2
`define RSP_SOF_BIT      3
`define RSP_TXDIS_BIT    4
`define RSP_WAIT_BIT     5

// ----------------------------------------
// interrupt status bits
// ----------------------------------------
`define IRQ_CMD_BIT      0
`define IRQ_RSP_BIT      1
`define IRQ_WIDTH        2
`endif

// file: inc/upper_err_pkg.sv
// Purpose: types for the upper chain port error flag block
// Assumes: nothing
// Notes:   carriers for received frame events
package upper_err_pkg;

	// one received byte with its framing information
	typedef struct packed
	{
		logic       valid;
		logic       sof;
		logic       isCommand;
		logic       typeValid;
		logic       byteError;
		logic       lastByte;
		logic       crcBad;
		logic       readCmd;
		logic [7:0] data;
	} rx_byte_s;

	// frame tracker states
	typedef enum logic [1:0]
	{
		WAIT_INIT,
		IN_FRAME,
		IGNORE
	} frame_state_e;

endpackage

// file: rtl/frame_tracker.sv
// Purpose: tracks frame position and ignore state on the upper chain port
// Assumes: bytes arrive with their framing decoded
// Notes:   emits one-cycle frame error events
`timescale 1ns/1ps

`include "upper_err_cfg.svh"

module frame_tracker
(
	input  wire logic                     ref_clk,
	input  wire logic                     rst_b,
	input  wire upper_err_pkg::rx_byte_s  rxByte,
	output logic                          initErr,
	output logic                          sofErr,
	output logic                          byteErr,
	output logic                          crcDiscard,
	output logic                          frameDone,
	output logic                          frameIsCmd,
	output logic                          frameIsRead
);

	upper_err_pkg::frame_state_e stateReg;
	upper_err_pkg::frame_state_e stateNext;
	logic                        isCmdReg;
	logic                        isCmdNext;
	logic                        isReadReg;
	logic                        isReadNext;
	logic                        pendSofReg;
	logic                        pendSofNext;
	logic                        pendByteReg;
	logic                        pendByteNext;

	// ----------------------------------------
	// frame sequencing
	// ----------------------------------------
	always_comb
	begin
		stateNext    = stateReg;
		isCmdNext    = isCmdReg;
		isReadNext   = isReadReg;
		pendSofNext  = pendSofReg;
		pendByteNext = pendByteReg;
		initErr      = 1'b0;
		sofErr       = 1'b0;
		byteErr      = 1'b0;
		crcDiscard   = 1'b0;
		frameDone    = 1'b0;
		frameIsCmd   = isCmdReg;
		frameIsRead  = isReadReg;
		if (rxByte.valid)
		begin
			case (stateReg)
				upper_err_pkg::WAIT_INIT:
				begin
					if (!rxByte.sof || !rxByte.typeValid)
					begin
						initErr   = 1'b1; // see [R1]
						stateNext = upper_err_pkg::IGNORE; // see [R2]
					end
					else
					begin
						isCmdNext    = rxByte.isCommand;
						isReadNext   = rxByte.readCmd;
						pendSofNext  = 1'b0;
						pendByteNext = 1'b0;
						stateNext    = upper_err_pkg::IN_FRAME;
					end
				end
				upper_err_pkg::IN_FRAME:
				begin
					if (rxByte.sof)
					begin
						pendSofNext = 1'b1; // see [R6]
					end
					if (rxByte.byteError)
					begin
						pendByteNext = 1'b1; // see [R7]
					end
					if (rxByte.lastByte)
					begin
						stateNext  = upper_err_pkg::WAIT_INIT;
						frameDone  = 1'b1;
						// a crc discard hides every other finding of the frame
						crcDiscard = rxByte.crcBad; // see [R10]
						sofErr     = !rxByte.crcBad && (pendSofReg || rxByte.sof); // see [R11]
						byteErr    = !rxByte.crcBad && (pendByteReg || rxByte.byteError); // see [R11]
					end
				end
				upper_err_pkg::IGNORE:
				begin
					// ignored bytes are checked for nothing and counted nowhere
					if (rxByte.sof && rxByte.typeValid) // see [R2] [R3]
					begin
						isCmdNext    = rxByte.isCommand;
						isReadNext   = rxByte.readCmd;
						pendSofNext  = 1'b0;
						pendByteNext = 1'b0;
						stateNext    = upper_err_pkg::IN_FRAME;
					end
				end
				default:
				begin
					stateNext = upper_err_pkg::WAIT_INIT;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			stateReg    <= upper_err_pkg::WAIT_INIT;
			isCmdReg    <= 1'b0;
			isReadReg   <= 1'b0;
			pendSofReg  <= 1'b0;
			pendByteReg <= 1'b0;
		end
		else
		begin
			stateReg    <= stateNext;
			isCmdReg    <= isCmdNext;
			isReadReg   <= isReadNext;
			pendSofReg  <= pendSofNext;
			pendByteReg <= pendByteNext;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_ignore_no_check: assert property (@(posedge ref_clk) disable iff (!rst_b) // see [R3]
		(stateReg == upper_err_pkg::IGNORE) |-> !(sofErr || byteErr || crcDiscard || frameDone))
		else $error("error reported while ignoring a frame");

	a_init_err_ignore: assert property (@(posedge ref_clk) disable iff (!rst_b) // see [R2]
		initErr |=> (stateReg == upper_err_pkg::IGNORE))
		else $error("init error did not enter ignore");

	a_crc_hides_rest: assert property (@(posedge ref_clk) disable iff (!rst_b) // see [R11]
		crcDiscard |-> !(sofErr || byteErr))
		else $error("crc discard reported other errors");

endmodule

// file: rtl/upper_link_frame_error_flags.sv
// Purpose: sticky error flags for frames received on the upper chain port
// Assumes: bytes arrive decoded and synchronous to ref_clk
// Notes:   both flag registers are read-only; a read of the interrupt status clears it
//
// Overview of operation
// [R1] malformed first byte sets init error flag
// [R2] after init error, skip until start byte
// [R3] ignored frames unchecked and uncounted
// [R4] forward every received byte up the stack
// [R5] dir 1, tx off, read: flag, discard
// [R6] dir 1: unexpected start bit flags error
// [R7] dir 1: non-init byte error flagged
// [R8] byte error may raise bit-level flags
// [R9] dir 0 command on upper: unexpected
// [R10] crc discard sets crc flag
// [R11] crc discard reports no other flags
// [R12] aborted pending stack response sets wait flag
// [R13] dir 0, tx off, response: flag, discard
// [R14] dir 1 response on upper: unexpected
// [R15] response errors flagged like command ones
// [R16] flags sticky, read-only, reset zero
`timescale 1ns/1ps

`include "upper_err_cfg.svh"

module upper_link_frame_error_flags
(
	input  wire logic                     ref_clk,
	input  wire logic                     rst_b,
	input  wire upper_err_pkg::rx_byte_s  rxByte,
	input  wire logic                     dirSel,
	input  wire logic                     upperTxDisabled,
	input  wire logic                     stackReadPending,
	input  wire logic                     responseAborted,
	input  wire logic [11:0]              regAddr,
	input  wire logic [7:0]               regWrData,
	input  wire logic                     regWr,
	input  wire logic                     regRd,
	output logic [7:0]                    regRdData,
	output logic                          fwdValid,
	output logic [7:0]                    fwdData,
	output logic                          discardPulse,
	output logic                          bitErrFlag,
	output logic                          irq
);

	logic       initErr;
	logic       sofErr;
	logic       byteErr;
	logic       crcDiscard;
	logic       frameDone;
	logic       frameIsCmd;
	logic       frameIsRead;
	logic [7:0] cmdFlagsReg;
	logic [7:0] cmdFlagsNext;
	logic [7:0] rspFlagsReg;
	logic [7:0] rspFlagsNext;
	logic [7:0] cmdSet;
	logic [7:0] rspSet;
	logic [`IRQ_WIDTH-1:0] irqStatReg;
	logic [`IRQ_WIDTH-1:0] irqStatNext;
	logic [`IRQ_WIDTH-1:0] irqMaskReg;
	logic [`IRQ_WIDTH-1:0] irqMaskNext;
	logic [7:0] rdDataReg;
	logic [7:0] rdDataNext;
	logic       fwdValidReg;
	logic [7:0] fwdDataReg;
	logic       discardReg;
	logic       discardNext;
	logic       bitErrReg;
	logic       irqReg;
	logic       irqNext;

	frame_tracker u_tracker
	(
		.ref_clk     (ref_clk),
		.rst_b       (rst_b),
		.rxByte      (rxByte),
		.initErr     (initErr),
		.sofErr      (sofErr),
		.byteErr     (byteErr),
		.crcDiscard  (crcDiscard),
		.frameDone   (frameDone),
		.frameIsCmd  (frameIsCmd),
		.frameIsRead (frameIsRead)
	);

	// ----------------------------------------
	// flag events
	// ----------------------------------------
	always_comb
	begin
		cmdSet = 8'h00;
		rspSet = 8'h00;
		cmdSet[`CMD_INIT_BIT] = initErr; // see [R1]
		if (frameDone && frameIsCmd)
		begin
			cmdSet[`CMD_CRC_BIT]   = crcDiscard; // see [R10]
			// a crc discard hides the direction mismatch as well
			cmdSet[`CMD_UNEXP_BIT] = !dirSel && !crcDiscard; // see [R9] [R11]
			cmdSet[`CMD_SOF_BIT]   = dirSel && sofErr; // see [R6]
			cmdSet[`CMD_BYTE_BIT]  = dirSel && byteErr; // see [R7]
			cmdSet[`CMD_TXDIS_BIT] = dirSel && upperTxDisabled && frameIsRead && !crcDiscard; // see [R5]
		end
		if (frameDone && !frameIsCmd)
		begin
			rspSet[`RSP_CRC_BIT]   = crcDiscard; // see [R15]
			rspSet[`RSP_UNEXP_BIT] = dirSel && !crcDiscard; // see [R14] [R15]
			rspSet[`RSP_SOF_BIT]   = sofErr; // see [R15]
			rspSet[`RSP_BYTE_BIT]  = byteErr; // see [R15]
			rspSet[`RSP_TXDIS_BIT] = !dirSel && upperTxDisabled && !crcDiscard; // see [R13]
		end
		rspSet[`RSP_WAIT_BIT] = stackReadPending && responseAborted; // see [R12]
	end

	// ----------------------------------------
	// sticky flags and register port
	// ----------------------------------------
	always_comb
	begin
		// flags only ever gain bits: software has no way to clear them
		cmdFlagsNext = cmdFlagsReg | cmdSet; // see [R16]
		rspFlagsNext = rspFlagsReg | rspSet; // see [R16]
		irqStatNext  = irqStatReg;
		irqMaskNext  = irqMaskReg;
		rdDataNext   = 8'h00;
		if (regWr && regAddr == `IRQ_MASK_OFS)
		begin
			irqMaskNext = regWrData[`IRQ_WIDTH-1:0];
		end
		if (regRd)
		begin
			case (regAddr)
				`CMD_FLAGS_OFS: rdDataNext = cmdFlagsReg;
				`RSP_FLAGS_OFS: rdDataNext = rspFlagsReg;
				`IRQ_STAT_OFS:
				begin
					rdDataNext  = {6'h00, irqStatReg};
					irqStatNext = '0;
				end
				`IRQ_MASK_OFS:  rdDataNext = {6'h00, irqMaskReg};
				default:        rdDataNext = 8'h00;
			endcase
		end
		// a new event wins over a clearing read in the same cycle
		irqStatNext[`IRQ_CMD_BIT] = irqStatNext[`IRQ_CMD_BIT] | (|cmdSet);
		irqStatNext[`IRQ_RSP_BIT] = irqStatNext[`IRQ_RSP_BIT] | (|rspSet);
		irqNext     = |(irqStatNext & irqMaskNext);
		discardNext = frameDone && (crcDiscard || cmdSet[`CMD_TXDIS_BIT] || rspSet[`RSP_TXDIS_BIT]); // see [R5] [R13]
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cmdFlagsReg <= `FLAGS_RESET;
			rspFlagsReg <= `FLAGS_RESET;
			irqStatReg  <= '0;
			irqMaskReg  <= '0;
			rdDataReg   <= 8'h00;
			fwdValidReg <= 1'b0;
			fwdDataReg  <= 8'h00;
			discardReg  <= 1'b0;
			bitErrReg   <= 1'b0;
			irqReg      <= 1'b0;
		end
		else
		begin
			cmdFlagsReg <= cmdFlagsNext;
			rspFlagsReg <= rspFlagsNext;
			irqStatReg  <= irqStatNext;
			irqMaskReg  <= irqMaskNext;
			rdDataReg   <= rdDataNext;
			// bytes pass on upward even when this device ignores them
			fwdValidReg <= rxByte.valid; // see [R4]
			fwdDataReg  <= rxByte.data; // see [R4]
			discardReg  <= discardNext;
			bitErrReg   <= rxByte.valid && rxByte.byteError; // see [R8]
			irqReg      <= irqNext;
		end
	end

	assign regRdData    = rdDataReg;
	assign fwdValid     = fwdValidReg;
	assign fwdData      = fwdDataReg;
	assign discardPulse = discardReg;
	assign bitErrFlag   = bitErrReg;
	assign irq          = irqReg;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_flags_sticky: assert property (@(posedge ref_clk) disable iff (!rst_b) // see [R16]
		((cmdFlagsReg & $past(cmdFlagsReg)) == $past(cmdFlagsReg))
		&& ((rspFlagsReg & $past(rspFlagsReg)) == $past(rspFlagsReg)) && (rspFlagsReg[7:6] == 2'h0))
		else $error("flag bit was lost");

	a_init_flag_set: assert property (@(posedge ref_clk) disable iff (!rst_b) // see [R1]
		initErr |=> cmdFlagsReg[`CMD_INIT_BIT])
		else $error("init error flag not set");

	a_unexp_cmd_flag: assert property (@(posedge ref_clk) disable iff (!rst_b) // see [R9]
		(frameDone && frameIsCmd && !dirSel && !crcDiscard) |=> cmdFlagsReg[`CMD_UNEXP_BIT])
		else $error("unexpected command not flagged");

	a_unexp_rsp_flag: assert property (@(posedge ref_clk) disable iff (!rst_b) // see [R14]
		(frameDone && !frameIsCmd && dirSel && !crcDiscard) |=> rspFlagsReg[`RSP_UNEXP_BIT])
		else $error("unexpected response not flagged");

	a_crc_flag_set: assert property (@(posedge ref_clk) disable iff (!rst_b) // see [R10]
		(crcDiscard && frameIsCmd) |=> cmdFlagsReg[`CMD_CRC_BIT] && discardPulse)
		else $error("crc discard not flagged");

	a_txdis_cmd: assert property (@(posedge ref_clk) disable iff (!rst_b) // see [R5]
		(frameDone && frameIsCmd && frameIsRead && dirSel && upperTxDisabled && !crcDiscard)
		|=> cmdFlagsReg[`CMD_TXDIS_BIT] && discardPulse)
		else $error("tx disabled read not flagged");

	a_txdis_rsp: assert property (@(posedge ref_clk) disable iff (!rst_b) // see [R13]
		(frameDone && !frameIsCmd && !dirSel && upperTxDisabled && !crcDiscard)
		|=> rspFlagsReg[`RSP_TXDIS_BIT] && discardPulse)
		else $error("tx disabled response not flagged");

	a_fwd_byte: assert property (@(posedge ref_clk) disable iff (!rst_b) // see [R4]
		rxByte.valid |=> fwdValid && (fwdData == $past(rxByte.data)))
		else $error("byte not forwarded");

	a_wait_flag: assert property (@(posedge ref_clk) disable iff (!rst_b) // see [R12]
		(stackReadPending && responseAborted) |=> rspFlagsReg[`RSP_WAIT_BIT])
		else $error("wait abort not flagged");

	a_sof_dir: assert property (@(posedge ref_clk) disable iff (!rst_b) // see [R6] [R7]
		(frameDone && frameIsCmd && dirSel && (sofErr || byteErr))
		|=> (cmdFlagsReg[`CMD_SOF_BIT] || cmdFlagsReg[`CMD_BYTE_BIT]))
		else $error("command frame error not flagged");

endmodule

// file: bench/stack_neighbor_model.sv
// Purpose: neighbour device that sends three-byte frames into the upper chain port
// Assumes: one frame request at a time, go pulsed for one cycle
// Notes:   data toggles while idle so a stale byte never looks fresh
`timescale 1ns/1ps

module stack_neighbor_model
(
	input  wire logic               ref_clk,
	input  wire logic               rst_b,
	input  wire logic               go,
	input  wire logic [6:0]         kind,
	output upper_err_pkg::rx_byte_s rxByte,
	output logic                    busy
);
	// kind: command, read, type ok, first sof, byte error, mid sof, crc bad
	upper_err_pkg::rx_byte_s byteNext;
	logic [1:0]              step_reg;
	logic [1:0]              step_next;

	always_comb
	begin
		byteNext = '0;
		byteNext.data = ~rxByte.data;
		step_next = 2'h0;
		case (step_reg)
			2'h0:
			begin
				if (go)
				begin
					byteNext.valid = 1'b1;
					byteNext.sof = kind[3];
					byteNext.typeValid = kind[4];
					byteNext.readCmd = kind[5];
					byteNext.data = 8'hA5;
					step_next = 2'h1;
				end
			end
			2'h1:
			begin
				byteNext.valid = 1'b1;
				byteNext.byteError = kind[2];
				byteNext.sof = kind[1];
				byteNext.data = 8'h5C;
				step_next = 2'h2;
			end
			default:
			begin
				byteNext.valid = 1'b1;
				byteNext.lastByte = 1'b1;
				byteNext.crcBad = kind[0];
				byteNext.data = 8'h3E;
			end
		endcase
		byteNext.isCommand = kind[6] & byteNext.valid;
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			step_reg <= 2'h0;
			rxByte <= '0;
		end
		else
		begin
			step_reg <= step_next;
			rxByte <= byteNext;
		end
	end

	assign busy = (step_reg != 2'h0);
endmodule

// file: bench/tb_upper_link_frame_error_flags.sv
// Purpose: self-checking bench for the upper chain port error flags
// Assumes: register reads answer one cycle after the strobe
// Notes:   flags are sticky, so expectations accumulate across frames
`timescale 1ns/1ps

`include "upper_err_cfg.svh"

module tb_upper_link_frame_error_flags;
	logic                    ref_clk;
	logic                    rst_b;
	upper_err_pkg::rx_byte_s rxByte;
	logic                    dirSel;
	logic                    upperTxDisabled;
	logic                    stackReadPending;
	logic                    responseAborted;
	logic [11:0]             regAddr;
	logic [7:0]              regWrData;
	logic                    regWr;
	logic                    regRd;
	logic [7:0]              regRdData;
	logic                    fwdValid;
	logic [7:0]              fwdData;
	logic                    discardPulse;
	logic                    bitErrFlag;
	logic                    irq;
	logic                    go;
	logic [6:0]              kind;
	logic                    busy;
	logic [7:0]              cmdExp;
	logic [7:0]              rspExp;
	int                      failures;
	int                      n_checks;
	int                      nDisc;
	int                      nFwd;
	int                      nBitErr;
	int                      expFwd;
	int                      b0;
	int                      fwdSum;
	int                      expSum;

	// ----------------------------------------
	// design and neighbour
	// ----------------------------------------
	upper_link_frame_error_flags u_upper_link_frame_error_flags (.ref_clk(ref_clk), .rst_b(rst_b),
		.rxByte(rxByte), .dirSel(dirSel), .upperTxDisabled(upperTxDisabled),
		.stackReadPending(stackReadPending), .responseAborted(responseAborted), .regAddr(regAddr),
		.regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
		.fwdValid(fwdValid), .fwdData(fwdData), .discardPulse(discardPulse),
		.bitErrFlag(bitErrFlag), .irq(irq));
	stack_neighbor_model u_stack_neighbor_model (.ref_clk(ref_clk), .rst_b(rst_b), .go(go),
		.kind(kind), .rxByte(rxByte), .busy(busy));

	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk)
	begin
		if (discardPulse === 1'b1) nDisc++;
		if (fwdValid === 1'b1) nFwd++;
		if (fwdValid === 1'b1) fwdSum += fwdData;
		if (bitErrFlag === 1'b1) nBitErr++;
	end

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task results();
		if (failures == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task chk8(input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task chkCnt(input int exp, input int got);
		n_checks++;
		if (got != exp)
		begin
			failures++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge ref_clk);
		regWr <= 1'b0;
	endtask

	task rdChk(input logic [11:0] a, input logic [7:0] exp);
		@(posedge ref_clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge ref_clk);
		regRd <= 1'b0;
		#1 chk8(exp, regRdData);
	endtask

	// a bounded wait: a stuck neighbour ends the run as a failure
	task frame(input logic [6:0] k, input int disc);
		int d0;
		int i;
		d0 = nDisc;
		@(posedge ref_clk);
		kind <= k;
		go <= 1'b1;
		@(posedge ref_clk);
		go <= 1'b0;
		i = 0;
		#1;
		while (busy === 1'b1 && i < 20)
		begin
			@(posedge ref_clk);
			#1 i++;
		end
		if (i >= 20)
		begin
			failures++;
			results();
		end
		repeat (3) @(posedge ref_clk);
		#1 chkCnt(d0 + disc, nDisc);
		expFwd += 3;
		expSum += 32'h13F;
		rdChk(`CMD_FLAGS_OFS, cmdExp);
		rdChk(`RSP_FLAGS_OFS, rspExp);
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		rst_b = 1'b0;
		dirSel = 1'b1;
		upperTxDisabled = 1'b0;
		stackReadPending = 1'b0;
		responseAborted = 1'b0;
		regAddr = '0;
		regWrData = '0;
		regWr = 1'b0;
		regRd = 1'b0;
		go = 1'b0;
		kind = '0;
		cmdExp = 8'h00;
		rspExp = 8'h00;
		failures = 0;
		n_checks = 0;
		nDisc = 0;
		nFwd = 0;
		nBitErr = 0;
		expFwd = 0;
		fwdSum = 0;
		expSum = 0;
		repeat (16) @(posedge ref_clk);
		rst_b <= 1'b1;
		rdChk(`CMD_FLAGS_OFS, 8'h00);
		rdChk(`RSP_FLAGS_OFS, 8'h00);
		wr(`CMD_FLAGS_OFS, 8'hFF);
		wr(`RSP_FLAGS_OFS, 8'hFF);
		rdChk(`CMD_FLAGS_OFS, 8'h00);
		rdChk(`RSP_FLAGS_OFS, 8'h00);
		rdChk(12'h7FF, 8'h00);
		rdChk(`IRQ_MASK_OFS, 8'h00);
		cmdExp = 8'h01;
		frame(7'b1011111, 1);
		chk8({7'h0, irq}, 8'h00);
		rdChk(`IRQ_STAT_OFS, 8'h01);
		rdChk(`IRQ_STAT_OFS, 8'h00);
		wr(`IRQ_MASK_OFS, 8'h03);
		rdChk(`IRQ_MASK_OFS, 8'h03);
		b0 = nBitErr;
		cmdExp |= 8'h04;
		frame(7'b1011100, 0);
		chkCnt(b0 + 1, nBitErr);
		chk8({7'h0, irq}, 8'h01);
		rdChk(`IRQ_STAT_OFS, 8'h01);
		repeat (2) @(posedge ref_clk);
		#1 chk8({7'h0, irq}, 8'h00);
		cmdExp |= 8'h08;
		frame(7'b1011010, 0);
		@(posedge ref_clk);
		upperTxDisabled <= 1'b1;
		cmdExp |= 8'h10;
		frame(7'b1111000, 1);
		@(posedge ref_clk);
		upperTxDisabled <= 1'b0;
		dirSel <= 1'b0;
		frame(7'b1011001, 1);
		cmdExp |= 8'h02;
		frame(7'b1011000, 0);
		@(posedge ref_clk);
		dirSel <= 1'b1;
		cmdExp |= 8'h20;
		frame(7'b1010101, 0);
		frame(7'b1010001, 0);
		frame(7'b1001000, 0);
		rspExp = 8'h01;
		frame(7'b0011001, 1);
		rspExp |= 8'h02;
		frame(7'b0011000, 0);
		@(posedge ref_clk);
		dirSel <= 1'b0;
		rspExp |= 8'h01;
		frame(7'b0011001, 1);
		rspExp |= 8'h04;
		frame(7'b0011100, 0);
		rspExp |= 8'h08;
		frame(7'b0011010, 0);
		@(posedge ref_clk);
		upperTxDisabled <= 1'b1;
		rspExp |= 8'h10;
		frame(7'b0011000, 1);
		@(posedge ref_clk);
		upperTxDisabled <= 1'b0;
		responseAborted <= 1'b1;
		@(posedge ref_clk);
		responseAborted <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rdChk(`RSP_FLAGS_OFS, rspExp);
		@(posedge ref_clk);
		stackReadPending <= 1'b1;
		@(posedge ref_clk);
		responseAborted <= 1'b1;
		@(posedge ref_clk);
		responseAborted <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rspExp |= 8'h20;
		rdChk(`RSP_FLAGS_OFS, rspExp);
		#1 chk8({7'h0, irq}, 8'h01);
		rdChk(`IRQ_STAT_OFS, 8'h03);
		rdChk(`CMD_FLAGS_OFS, cmdExp);
		chkCnt(expFwd, nFwd);
		chkCnt(expSum, fwdSum);
		results();
	end
endmodule
